// *** core/isb_pkg.sv ***
// Shared constants, state encodings and state record for the I2C status/enable/baud block
package isb_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int BRG_W = 9;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_TXB  = 8'h08;
  localparam logic [7:0] A_RXB  = 8'h0c;
  localparam logic [7:0] A_BRG  = 8'h10;
  localparam logic [7:0] A_OWN  = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CT_EN    = 15;
  localparam int CT_GCEN  = 7;
  localparam int CT_ACKDT = 5;
  localparam int CT_ACKEN = 4;
  localparam int CT_RCEN  = 3;
  localparam int CT_PEN   = 2;
  localparam int CT_RSEN  = 1;
  localparam int CT_SEN   = 0;
  localparam int ST_ACK   = 15;
  localparam int ST_TRS   = 14;
  localparam int ST_BCL   = 10;
  localparam int ST_GC    = 9;
  localparam int ST_IWCOL = 7;
  localparam int ST_OV    = 6;
  localparam int ST_DA    = 5;
  localparam int ST_STOP  = 4;
  localparam int ST_START = 3;
  localparam int ST_RW    = 2;
  localparam int ST_RBF   = 1;
  localparam int ST_TBF   = 0;

  // ****************************************
  // Masks and values after reset
  // ****************************************
  localparam logic [15:0] CTRL_WMASK = 16'hbfff;
  localparam logic [15:0] STAT_CMASK = 16'h04c0;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] STAT_RST   = 16'h0000;
  localparam logic [BRG_W-1:0] BRG_RST = 9'h000;
  localparam logic [6:0] OWN_RST     = 7'h00;
  localparam logic [7:0] GC_ADDR     = 8'h00;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [3:0] {
    M_IDLE  = 4'h0, M_STA_A = 4'h1, M_STA_B = 4'h2, M_RST_A = 4'h3,
    M_RST_B = 4'h4, M_STP_A = 4'h5, M_STP_B = 4'h6, M_STP_C = 4'h7,
    M_BIT_L = 4'h8, M_BIT_H = 4'h9
  } isb_mst_t;

  typedef enum logic [1:0] {
    K_TX = 2'h0, K_RX = 2'h1, K_ACK = 2'h2
  } isb_kind_t;

  typedef struct packed {
    logic [1:0]       scl_sy;
    logic [1:0]       sda_sy;
    logic             scl_d;
    logic             sda_d;
    logic [15:0]      ctrl;
    logic [15:0]      stat;
    logic [7:0]       txb;
    logic [7:0]       rxb;
    logic [BRG_W-1:0] brg;
    logic [6:0]       own;
    isb_mst_t         m_st;
    isb_kind_t        m_kind;
    logic [3:0]       m_cnt;
    logic [7:0]       m_sh;
    logic             m_scl_lo;
    logic             m_sda_lo;
    logic             m_tx_go;
    logic             s_act;
    logic             s_addr;
    logic             s_tx;
    logic [3:0]       s_cnt;
    logic [7:0]       s_sh;
    logic             s_lo;
    logic             wb_ack;
    logic [31:0]      wb_dat;
    logic             mirq;
    logic             sirq;
    logic             scl_oe;
    logic             sda_oe;
    logic             pins_own;
    logic             pin_lvl;
  } isb_state_t;

endpackage : isb_pkg

// *** core/isb_baud.sv ***
// Baud interval generator: loads the reload value, counts down to zero and stops
`timescale 1ns/100ps
module isb_baud #(
  parameter int BRG_W = isb_pkg::BRG_W
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             load,
  input  wire logic [BRG_W-1:0] reload_val,
  // Status
  output logic                  cnt_zero
);

  logic [BRG_W-1:0] cnt_reg;
  logic [BRG_W-1:0] cnt_next;

  // One decrement per clock; an instruction cycle is two clocks
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = reload_val; // see R16
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1; // see R17
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Not gated by load: the master loads on this flag, so gating would close a loop
  assign cnt_zero = (cnt_reg == '0);

endmodule : isb_baud

// *** core/isb_core.sv ***
// I2C master/slave core with status flags, enable handling and baud timing
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
// Notes on behaviour
// R01: stop-seen flag updates on each start or stop; set when stop was last.
// R02: start-seen flag updates on each start or stop; set when start was last.
// R03: slave stores direction bit of the received address byte.
// R04: receive-full flag sets when a byte lands in the receive buffer.
// R05: reading the receive buffer clears the receive-full flag.
// R06: writing the transmit buffer sets the transmit-full flag.
// R07: transmit-full flag clears when eight bits have shifted out.
// R08: the enable bit turns on master and slave logic together.
// R09: on enable both bus lines are released, bus idle.
// R10: master stays idle until software requests a master event.
// R11: enabled slave watches for start then matching address to begin.
// R12: while enabled the block owns line direction and level.
// R13: separate master and slave event requests go to the system.
// R14: master request on start, stop, restart, byte, ack done, collision.
// R15: slave request on address match, transmit request, byte received.
// R16: baud counter loads reload value, counts to zero, then stops.
// R17: baud counter decrements twice per instruction cycle.
// R18: baud counter reloads at restart; while clock stretched, when SCL seen high.
// R19: software must never program a zero baud reload value.
// R20: as master, one SCL period is two baud intervals, low and high.
// R21: software derives the reload value from clock and bus rates.
// R22: while disabled, all engines stay idle and lines are released.
module isb_core (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Bus lines
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // System side
  output logic             pins_owned,
  output logic             master_event_irq,
  output logic             slave_event_irq
);

  isb_pkg::isb_state_t r;
  isb_pkg::isb_state_t n;
  logic                bload;
  logic                bzero;

  // Level to drive low for one master bit slot
  function automatic logic m_drv(input isb_pkg::isb_kind_t k, input logic [3:0] c,
                                 input logic [7:0] sh, input logic ackdt);
    logic v;
    v = 1'b0;
    if (k == isb_pkg::K_TX && c < 4'h8) begin
      v = ~sh[7];
    end else if (k == isb_pkg::K_ACK) begin
      v = ~ackdt;
    end
    return v;
  endfunction : m_drv

  isb_baud #(
    .BRG_W (isb_pkg::BRG_W)
  ) u_baud (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .load       (bload),
    .reload_val (r.brg),
    .cnt_zero   (bzero)
  );

  always_comb begin
    logic        en;
    logic        req;
    logic [15:0] wm;
    logic        m_busy;
    logic        scl_s;
    logic        sda_s;
    logic        st_det;
    logic        sp_det;
    logic        dv;
    logic [7:0]  dvb;
    logic        done;
    logic [7:0]  sh;
    n      = r;
    bload  = 1'b0;
    dv     = 1'b0;
    dvb    = 8'h00;
    done   = 1'b0;
    sh     = r.m_sh;
    n.mirq = 1'b0;
    n.sirq = 1'b0;
    en     = r.ctrl[isb_pkg::CT_EN];
    // ****************************************
    // Line synchronisers and condition detect
    // ****************************************
    n.scl_sy = {r.scl_sy[0], scl_i};
    n.sda_sy = {r.sda_sy[0], sda_i};
    scl_s    = r.scl_sy[1];
    sda_s    = r.sda_sy[1];
    n.scl_d  = scl_s;
    n.sda_d  = sda_s;
    st_det   = r.sda_d & ~sda_s & scl_s & r.scl_d;
    sp_det   = ~r.sda_d & sda_s & scl_s & r.scl_d;
    m_busy   = (r.m_st != isb_pkg::M_IDLE) || r.m_tx_go || (r.ctrl[4:0] != 5'h00);

    // ****************************************
    // Register bus: software effects come first so hardware sets win
    // ****************************************
    req      = wb_cyc_i & wb_stb_i & ~r.wb_ack;
    n.wb_ack = req;
    wm       = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    if (req) begin
      case (wb_adr_i)
        isb_pkg::A_CTRL: n.wb_dat = {16'h0000, r.ctrl};
        isb_pkg::A_STAT: n.wb_dat = {16'h0000, r.stat};
        isb_pkg::A_TXB:  n.wb_dat = {24'h000000, r.txb};
        isb_pkg::A_RXB:  n.wb_dat = {24'h000000, r.rxb};
        isb_pkg::A_BRG:  n.wb_dat = 32'(r.brg);
        isb_pkg::A_OWN:  n.wb_dat = {25'h0000000, r.own};
        default:         n.wb_dat = 32'h00000000;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          isb_pkg::A_CTRL: begin
            wm = wm & isb_pkg::CTRL_WMASK;
            // Event bits are locked while the master is busy: no queueing
            if (m_busy) begin
              wm[4:0] = 5'h00;
            end
            n.ctrl = (r.ctrl & ~wm) | (wb_dat_i[15:0] & wm); // see R08 R10
          end
          isb_pkg::A_STAT: n.stat = r.stat & ~(isb_pkg::STAT_CMASK & wm & ~wb_dat_i[15:0]);
          isb_pkg::A_TXB: begin
            if (wb_sel_i[0]) begin
              if (r.stat[isb_pkg::ST_TBF] || r.m_st != isb_pkg::M_IDLE) begin
                n.stat[isb_pkg::ST_IWCOL] = 1'b1;
              end else begin
                n.txb = wb_dat_i[7:0];
                n.stat[isb_pkg::ST_TBF] = 1'b1; // see R06
                n.m_tx_go = ~(r.s_act & r.stat[isb_pkg::ST_RW]);
              end
            end
          end
          isb_pkg::A_BRG: begin
            if (wb_sel_i[0]) begin
              n.brg[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              n.brg[isb_pkg::BRG_W-1:8] = wb_dat_i[isb_pkg::BRG_W-1:8];
            end
          end
          isb_pkg::A_OWN: begin
            if (wb_sel_i[0]) begin
              n.own = wb_dat_i[6:0];
            end
          end
          default: n.wb_dat = 32'h00000000;
        endcase
      end else if (wb_adr_i == isb_pkg::A_RXB) begin
        n.stat[isb_pkg::ST_RBF] = 1'b0; // see R05
      end
    end

    // ****************************************
    // Master engine
    // ****************************************
    if (en) begin
      case (r.m_st)
        isb_pkg::M_IDLE: begin
          if (r.ctrl[isb_pkg::CT_SEN]) begin
            n.m_st = isb_pkg::M_STA_A;
            bload  = 1'b1;
          end else if (r.ctrl[isb_pkg::CT_RSEN]) begin
            n.m_sda_lo = 1'b0;
            n.m_st     = isb_pkg::M_RST_A;
            bload      = 1'b1;
          end else if (r.ctrl[isb_pkg::CT_PEN]) begin
            n.m_sda_lo = 1'b1;
            n.m_st     = isb_pkg::M_STP_A;
            bload      = 1'b1;
          end else if (r.ctrl[isb_pkg::CT_RCEN] || r.ctrl[isb_pkg::CT_ACKEN] || r.m_tx_go) begin
            if (r.ctrl[isb_pkg::CT_RCEN]) begin
              n.m_kind = isb_pkg::K_RX;
            end else if (r.ctrl[isb_pkg::CT_ACKEN]) begin
              n.m_kind = isb_pkg::K_ACK;
            end else begin
              n.m_kind  = isb_pkg::K_TX;
              n.m_sh    = r.txb;
              n.m_tx_go = 1'b0;
              n.stat[isb_pkg::ST_TRS] = 1'b1;
            end
            n.m_cnt    = 4'h0;
            n.m_scl_lo = 1'b1;
            n.m_sda_lo = m_drv(n.m_kind, 4'h0, n.m_sh, r.ctrl[isb_pkg::CT_ACKDT]);
            n.m_st     = isb_pkg::M_BIT_L;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_STA_A: begin
          if (bzero) begin
            n.m_sda_lo = 1'b1;
            n.m_st     = isb_pkg::M_STA_B;
            bload      = 1'b1; // see R18
          end
        end
        isb_pkg::M_STA_B: begin
          if (bzero) begin
            n.m_scl_lo = 1'b1;
            n.ctrl[isb_pkg::CT_SEN]  = 1'b0;
            n.ctrl[isb_pkg::CT_RSEN] = 1'b0;
            n.mirq = 1'b1; // see R14
            n.m_st = isb_pkg::M_IDLE;
          end
        end
        isb_pkg::M_RST_A: begin
          if (bzero) begin
            n.m_scl_lo = 1'b0;
            n.m_st     = isb_pkg::M_RST_B;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_RST_B: begin
          if (!scl_s) begin
            bload = 1'b1; // see R18
          end else if (bzero) begin
            n.m_sda_lo = 1'b1;
            n.m_st     = isb_pkg::M_STA_B;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_STP_A: begin
          if (bzero) begin
            n.m_scl_lo = 1'b0;
            n.m_st     = isb_pkg::M_STP_B;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_STP_B: begin
          if (!scl_s) begin
            bload = 1'b1; // see R18
          end else if (bzero) begin
            n.m_sda_lo = 1'b0;
            n.m_st     = isb_pkg::M_STP_C;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_STP_C: begin
          if (bzero) begin
            n.ctrl[isb_pkg::CT_PEN] = 1'b0;
            n.mirq = 1'b1; // see R14
            n.m_st = isb_pkg::M_IDLE;
          end
        end
        isb_pkg::M_BIT_L: begin
          if (bzero) begin
            n.m_scl_lo = 1'b0; // see R20
            n.m_st     = isb_pkg::M_BIT_H;
            bload      = 1'b1;
          end
        end
        isb_pkg::M_BIT_H: begin
          if (!scl_s) begin
            bload = 1'b1; // see R18
          end else if (r.m_kind == isb_pkg::K_TX && r.m_cnt < 4'h8 && !r.m_sda_lo && !sda_s) begin
            // Another master holds SDA low: back off and release both lines
            n.stat[isb_pkg::ST_BCL] = 1'b1;
            n.stat[isb_pkg::ST_TRS] = 1'b0;
            n.stat[isb_pkg::ST_TBF] = 1'b0;
            n.m_scl_lo = 1'b0;
            n.m_sda_lo = 1'b0;
            n.mirq     = 1'b1; // see R14
            n.m_st     = isb_pkg::M_IDLE;
          end else if (bzero) begin
            n.m_scl_lo = 1'b1; // see R20
            n.m_cnt    = r.m_cnt + 4'h1;
            case (r.m_kind)
              isb_pkg::K_TX: begin
                sh = {r.m_sh[6:0], 1'b0};
                if (r.m_cnt == 4'h7) begin
                  n.stat[isb_pkg::ST_TBF] = 1'b0; // see R07
                end
                if (r.m_cnt == 4'h8) begin
                  n.stat[isb_pkg::ST_ACK] = sda_s;
                  n.stat[isb_pkg::ST_TRS] = 1'b0;
                  done = 1'b1;
                end
              end
              isb_pkg::K_RX: begin
                sh = {r.m_sh[6:0], sda_s};
                if (r.m_cnt == 4'h7) begin
                  n.ctrl[isb_pkg::CT_RCEN] = 1'b0;
                  dv   = 1'b1;
                  dvb  = sh;
                  done = 1'b1;
                end
              end
              default: begin
                n.ctrl[isb_pkg::CT_ACKEN] = 1'b0;
                done = 1'b1;
              end
            endcase
            n.m_sh = sh;
            if (done) begin
              n.m_sda_lo = 1'b0;
              n.mirq     = 1'b1; // see R14
              n.m_st     = isb_pkg::M_IDLE;
            end else begin
              n.m_sda_lo = m_drv(r.m_kind, n.m_cnt, sh, r.ctrl[isb_pkg::CT_ACKDT]);
              n.m_st     = isb_pkg::M_BIT_L;
              bload      = 1'b1;
            end
          end
        end
        default: n.m_st = isb_pkg::M_IDLE;
      endcase

      // ****************************************
      // Slave engine
      // ****************************************
      if (st_det) begin
        n.stat[isb_pkg::ST_START] = 1'b1; // see R02
        n.stat[isb_pkg::ST_STOP]  = 1'b0; // see R01
        n.s_act  = 1'b1; // see R11
        n.s_addr = 1'b1;
        n.s_tx   = 1'b0;
        n.s_cnt  = 4'hf; // Wraps to zero at the start's own SCL fall
        n.s_lo   = 1'b0;
      end else if (sp_det) begin
        n.stat[isb_pkg::ST_STOP]  = 1'b1; // see R01
        n.stat[isb_pkg::ST_START] = 1'b0; // see R02
        n.stat[isb_pkg::ST_GC]    = 1'b0;
        n.s_act = 1'b0;
        n.s_tx  = 1'b0;
        n.s_lo  = 1'b0;
      end else if (r.s_act && scl_s && !r.scl_d) begin
        if (r.s_cnt < 4'h8 && !r.s_tx) begin
          n.s_sh = {r.s_sh[6:0], sda_s};
        end else if (r.s_cnt == 4'h8 && r.s_tx && sda_s) begin
          // Master refused the byte: transmission ends here
          n.s_act = 1'b0;
          n.s_tx  = 1'b0;
        end
      end else if (r.s_act && !scl_s && r.scl_d) begin
        if (r.s_cnt == 4'h7) begin
          n.s_cnt = 4'h8;
          if (r.s_tx) begin
            n.s_lo = 1'b0;
            n.stat[isb_pkg::ST_TBF] = 1'b0; // see R07
          end else if (r.s_addr) begin
            if (r.s_sh[7:1] == r.own ||
                (r.ctrl[isb_pkg::CT_GCEN] && r.s_sh == isb_pkg::GC_ADDR)) begin
              n.s_lo = 1'b1;
              n.stat[isb_pkg::ST_RW] = r.s_sh[0]; // see R03
              n.stat[isb_pkg::ST_DA] = 1'b0;
              n.stat[isb_pkg::ST_GC] = (r.s_sh == isb_pkg::GC_ADDR);
              n.sirq = 1'b1; // see R15
              dv     = 1'b1;
              dvb    = r.s_sh;
            end else begin
              n.s_act = 1'b0;
            end
          end else begin
            n.s_lo = 1'b1;
            n.stat[isb_pkg::ST_DA] = 1'b1;
            n.sirq = 1'b1; // see R15
            dv     = 1'b1;
            dvb    = r.s_sh;
          end
        end else if (r.s_cnt == 4'h8) begin
          n.s_cnt  = 4'h0;
          n.s_addr = 1'b0;
          n.s_lo   = 1'b0;
          if (r.stat[isb_pkg::ST_RW] && (r.s_addr || r.s_tx)) begin
            n.s_tx = 1'b1;
            n.s_sh = r.txb;
            n.s_lo = ~r.txb[7];
            n.sirq = r.s_tx; // see R15
          end
        end else begin
          n.s_cnt = r.s_cnt + 4'h1;
          if (r.s_tx) begin
            n.s_sh = {r.s_sh[6:0], 1'b0};
            n.s_lo = ~r.s_sh[6];
          end
        end
      end

      // Received byte into the holding buffer, or overflow if still full
      if (dv) begin
        if (n.stat[isb_pkg::ST_RBF]) begin
          n.stat[isb_pkg::ST_OV] = 1'b1;
        end else begin
          n.rxb = dvb;
          n.stat[isb_pkg::ST_RBF] = 1'b1; // see R04
        end
      end
    end else begin
      // Disabled: engines held idle, baud counter kept loaded
      n.m_st     = isb_pkg::M_IDLE; // see R22
      n.m_scl_lo = 1'b0;
      n.m_sda_lo = 1'b0;
      n.m_tx_go  = 1'b0;
      n.s_act    = 1'b0;
      n.s_tx     = 1'b0;
      n.s_lo     = 1'b0;
      bload      = 1'b1;
    end

    // ****************************************
    // Pin ownership and drive
    // ****************************************
    n.pins_own = n.ctrl[isb_pkg::CT_EN]; // see R12
    n.scl_oe   = n.pins_own & n.m_scl_lo & en; // see R09
    n.sda_oe   = n.pins_own & (n.m_sda_lo | n.s_lo) & en; // see R09
    n.pin_lvl  = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o         = r.wb_dat;
  assign wb_ack_o         = r.wb_ack;
  assign scl_o            = r.pin_lvl;
  assign sda_o            = r.pin_lvl;
  assign scl_oe           = r.scl_oe;
  assign sda_oe           = r.sda_oe;
  assign pins_owned       = r.pins_own;
  assign master_event_irq = r.mirq; // see R13
  assign slave_event_irq  = r.sirq; // see R13

endmodule : isb_core

// *** test/isb_props.sv ***
// Port-level assertions for the I2C status, enable and baud block
`timescale 1ns/100ps
module isb_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Bus lines and system side
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        pins_owned,
  input wire logic        master_event_irq,
  input wire logic        slave_event_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ********
  // Sequences
  // ********
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Two cycles off, so the registered line enables have had time to drop
  sequence s_off2;
    !pins_owned ##1 !pins_owned;
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rxb_width: assert property (s_req ##0 !wb_we_i && wb_adr_i == isb_pkg::A_RXB |=>
    wb_dat_o[31:8] == 24'h0)
    else $error("receive buffer upper bits not zero");
  a_idle_lines: assert property (s_off2 |-> !scl_oe && !sda_oe)
    else $error("line pulled while disabled");
  a_enable_release: assert property ($rose(pins_owned) |-> !scl_oe && !sda_oe)
    else $error("line pulled at enable");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  a_mirq_pulse: assert property (master_event_irq |=> !master_event_irq)
    else $error("master request not a pulse");
  a_sirq_pulse: assert property (slave_event_irq |=> !slave_event_irq)
    else $error("slave request not a pulse");
  a_irq_enabled: assert property (master_event_irq || slave_event_irq |-> pins_owned)
    else $error("request while disabled");
endmodule : isb_props
bind isb_core isb_props u_props (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .scl_o, .scl_oe, .sda_o, .sda_oe, .pins_owned,
  .master_event_irq, .slave_event_irq);

// *** test/isb_slave_model.sv ***
// Behavioural I2C slave that acknowledges bytes and keeps the last one
`timescale 1ns/100ps
module isb_slave_model (
  // Wire levels
  input wire logic  scl,
  input wire logic  sda,
  // Control and result
  input wire logic  ack_en,
  output logic      sda_pull,
  output logic [7:0] rx_byte
);
  int        cnt;
  logic [7:0] sh;
  initial begin
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    cnt = 0;
  end
  // The start's own SCL fall moves the count to zero
  // SDA may move in the same step as an SCL fall; judge SCL once it has settled
  always @(negedge sda) #1 if (scl === 1'b1) cnt = -1;
  always @(posedge scl) if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
  always @(negedge scl) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      rx_byte = sh;
      sda_pull = ack_en;
    end else if (cnt == 9) begin
      sda_pull = 1'b0;
      cnt = 0;
    end
  end
endmodule : isb_slave_model

// *** test/tb_top.sv ***
// Self-checking bench for the I2C status, enable and baud block
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, m_byte;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic scl_o, scl_oe, sda_o, sda_oe, pins_owned, master_event_irq, slave_event_irq;
  logic tb_scl_lo, tb_sda_lo, m_pull, m_ack_en, ack;
  int mirq_cnt, sirq_cnt, miscompares, n_checks;
  wire scl = !(scl_oe | tb_scl_lo);
  wire sda = !(sda_oe | tb_sda_lo | m_pull);
  isb_core dut_u (.ref_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_i(scl), .scl_o, .scl_oe,
    .sda_i(sda), .sda_o, .sda_oe, .pins_owned, .master_event_irq, .slave_event_irq);
  isb_slave_model mdl_u (.scl, .sda, .ack_en(m_ack_en), .sda_pull(m_pull), .rx_byte(m_byte));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (master_event_irq === 1'b1) mirq_cnt++;
  always @(posedge ref_clk) if (slave_event_irq === 1'b1) sirq_cnt++;
  // ********
  // Helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    int t;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 16'h0, d};
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    chk(t < 50, 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask : rdchk
  task automatic wmirq;
    int t, c0;
    c0 = mirq_cnt;
    t = 0;
    while (mirq_cnt == c0 && t < 1000) begin
      @(posedge ref_clk);
      t++;
    end
    chk(t < 1000, 1'b1);
  endtask : wmirq
  // One quarter of a 160 ns link bit; arguments say which line the bench pulls low
  task automatic ph(input logic c, input logic d);
    @(posedge ref_clk);
    {tb_scl_lo, tb_sda_lo} <= {c, d};
    @(posedge ref_clk);
  endtask : ph
  task automatic bstart; ph(0, 0); ph(0, 1); ph(1, 1); endtask : bstart
  // Trailing idle quarter lets the synchronised stop reach the status before a read
  task automatic bstop; ph(1, 1); ph(0, 1); ph(0, 0); ph(0, 0); endtask : bstop
  task automatic bbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      ph(1, !v[i]); ph(0, !v[i]); ph(0, !v[i]); ph(1, !v[i]);
    end
    ph(1, 0); ph(0, 0); ph(0, 0);
    ack = sda;
    ph(1, 0);
  endtask : bbyte
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // ********
  // Scenarios
  // ********
  task automatic t_disabled;
    chk({pins_owned, scl_oe, sda_oe}, 3'b000);
    rdchk(isb_pkg::A_STAT, 32'h0);
    rdchk(8'h18, 32'h0);
    bstart; bstop;
    rdchk(isb_pkg::A_STAT, 32'h0);
  endtask : t_disabled
  task automatic t_slave;
    wr(isb_pkg::A_OWN, 16'h002a);
    wr(isb_pkg::A_BRG, 16'h0004);
    wr(isb_pkg::A_CTRL, 16'h8000);
    chk({pins_owned, scl_oe, sda_oe}, 3'b100);
    bstart;
    rdchk(isb_pkg::A_STAT, 32'h0008);
    bbyte(8'h54);
    chk(ack, 1'b0);
    chk(sirq_cnt, 1);
    chk(mirq_cnt, 0);
    rdchk(isb_pkg::A_STAT, 32'h000a);
    rdchk(isb_pkg::A_RXB, 32'h0054);
    rdchk(isb_pkg::A_STAT, 32'h0008);
    bstop;
    rdchk(isb_pkg::A_STAT, 32'h0010);
  endtask : t_slave
  task automatic t_master;
    m_ack_en <= 1'b1;
    wr(isb_pkg::A_CTRL, 16'h8001);
    wmirq;
    rdchk(isb_pkg::A_CTRL, 32'h8000);
    rdchk(isb_pkg::A_STAT, 32'h0008);
    wr(isb_pkg::A_TXB, 16'h00a5);
    rdchk(isb_pkg::A_STAT, 32'h4009);
    wmirq;
    rdchk(isb_pkg::A_STAT, 32'h0008);
    chk(m_byte, 8'ha5);
    wr(isb_pkg::A_CTRL, 16'h8004);
    wmirq;
    rdchk(isb_pkg::A_STAT, 32'h0010);
    wr(isb_pkg::A_CTRL, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk({pins_owned, scl_oe, sda_oe}, 3'b000);
  endtask : t_master
  initial begin
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h3;
    {tb_scl_lo, tb_sda_lo, m_ack_en} = 3'b000;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_disabled;
    t_slave;
    t_master;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    print_verdict;
  end
endmodule : tb_top
